// file: inc/srs_pkg.sv
// Purpose: constants and types of the security register / reset / suspend command logic
// Assumes: 250 MHz core clock
// Notes: opcodes are the byte values seen on the serial lines
package srs_pkg;
	localparam int CLK_PERIOD_NS = 4;
	localparam logic [7:0] OP_LATCH_SET = 8'h06;
	localparam logic [7:0] OP_LATCH_CLR = 8'h04;
	localparam logic [7:0] OP_SEC_ERASE = 8'h44;
	localparam logic [7:0] OP_SEC_PROG = 8'h42;
	localparam logic [7:0] OP_SEC_READ = 8'h48;
	localparam logic [7:0] OP_RST_EN = 8'h66;
	localparam logic [7:0] OP_RST = 8'h99;
	localparam logic [7:0] OP_WRAP_READ = 8'h0C;
	localparam logic [7:0] OP_SET_PARAM = 8'hC0;
	localparam logic [7:0] OP_SUSPEND = 8'h75;
	localparam logic [7:0] OP_RESUME = 8'h7A;
	localparam logic [7:0] OP_PP = 8'h02;
	localparam logic [7:0] OP_QPP = 8'h32;
	localparam logic [7:0] OP_SE = 8'h20;
	localparam logic [7:0] OP_BE32 = 8'h52;
	localparam logic [7:0] OP_BE64 = 8'hD8;
	localparam logic [7:0] OP_CE1 = 8'hC7;
	localparam logic [7:0] OP_CE2 = 8'h60;
	localparam int SECREG_COUNT = 3;
	localparam int SECREG_BYTES = 1024;
	localparam int PAGE_BYTES = 256;
	localparam int SEL_LSB = 12;
	localparam int DUMMY_LSB = 4;
	localparam int WRAP_LSB = 0;
	localparam logic [7:0] READ_PARAM_RESET = 8'h00;
	localparam logic [3:0] SEC_DUMMY_SPI = 4'h8;
	localparam logic [3:0] SEC_DUMMY_QPI = 4'h2;
	localparam int SUSPEND_LATENCY_NS = 1000;
	localparam int SUSPEND_CYCLES = SUSPEND_LATENCY_NS / CLK_PERIOD_NS;
	localparam int RESUME_TIME_NS = 200;
	localparam int RESUME_CYCLES = RESUME_TIME_NS / CLK_PERIOD_NS;
	typedef enum logic [2:0] {K_NONE, K_MAIN_PROG, K_MAIN_ERASE, K_CHIP_ERASE,
		K_SEC_ERASE, K_SEC_PROG} srs_kind_type;
	typedef enum logic [2:0] {ST_IDLE, ST_RUN, ST_SUSP_WAIT, ST_SUSP, ST_NEST,
		ST_RES_WAIT} srs_state_type;
endpackage

// file: core/srs_cmd.sv
// Purpose: serial flash command logic for security registers, soft reset, wrap read, suspend
// Assumes: sclk at most a quarter of clk_i; lock bits and mode come from same-clock logic
// Notes: array bytes for the wrap read come from outside one cycle after array_addr_o
`timescale 1ns/1ps
module srs_fifo #(parameter int WIDTH = 8, parameter int DEPTH = 4) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0] count;
	logic push;
	logic pop;
	assign in_ready_o = (count != (AW+1)'(DEPTH));
	assign out_valid_o = (count != '0);
	assign out_data_o = mem[rd_ptr];
	assign push = in_valid_i && in_ready_o;
	assign pop = out_valid_o && out_ready_i;
	always_ff @(posedge clk_i) begin
		if (push) begin
			mem[wr_ptr] <= in_data_i;
		end
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			if (push) begin
				wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
			end
			if (push && !pop) begin
				count <= count + 1'b1;
			end else if (pop && !push) begin
				count <= count - 1'b1;
			end
		end
	end
endmodule

module srs_cmd import srs_pkg::*; #(
	parameter int SECREG_ERASE_TIME_US = 20,
	parameter int SECREG_PROG_TIME_US = 4,
	parameter int MAIN_OP_TIME_US = 20,
	parameter int RESET_RECOVERY_US = 20,
	parameter int FIFO_DEPTH = 4
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cs_n_i,
	input wire logic sclk_i,
	input wire logic [3:0] io_i,
	output logic [3:0] io_o,
	output logic [3:0] io_oe_o,
	input wire logic four_line_command_mode_i,
	input wire logic otp_lock_bit_one_i,
	input wire logic otp_lock_bit_two_i,
	input wire logic otp_lock_bit_three_i,
	input wire logic [7:0] array_data_i,
	output logic [23:0] array_addr_o,
	output logic write_in_progress_flag_o,
	output logic write_latch_flag_o,
	output logic [1:0] suspend_flags_o,
	output logic [7:0] read_param_bits_o
);
	localparam int ERASE_CYC = (SECREG_ERASE_TIME_US*1000 + CLK_PERIOD_NS-1) / CLK_PERIOD_NS;
	localparam int PROG_CYC = (SECREG_PROG_TIME_US*1000 + CLK_PERIOD_NS-1) / CLK_PERIOD_NS;
	localparam int MAIN_CYC = (MAIN_OP_TIME_US*1000 + CLK_PERIOD_NS-1) / CLK_PERIOD_NS;
	localparam int RECOV_CYC = (RESET_RECOVERY_US*1000 + CLK_PERIOD_NS-1) / CLK_PERIOD_NS;
	// the timed count never ends before the byte walk it covers
	localparam int SE_CYC = (ERASE_CYC > SECREG_BYTES) ? ERASE_CYC : SECREG_BYTES + 1;
	localparam int SP_CYC = (PROG_CYC > PAGE_BYTES) ? PROG_CYC : PAGE_BYTES + 1;
	localparam int MC_CYC = (MAIN_CYC > 0) ? MAIN_CYC : 1;
	localparam int SUS_MAX = 250;
	localparam int RES_MAX = 50;
	// --------------------------------------------------------------
	// pin synchronisers
	// --------------------------------------------------------------
	logic [1:0] cs_sync;
	logic [1:0] sclk_sync;
	logic [3:0] io_m;
	logic [3:0] io_s;
	logic cs_d;
	logic sclk_d;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cs_sync <= 2'h3;
			sclk_sync <= 2'h0;
			io_m <= 4'h0;
			io_s <= 4'h0;
			cs_d <= 1'b1;
			sclk_d <= 1'b0;
		end else begin
			cs_sync <= {cs_sync[0], cs_n_i};
			sclk_sync <= {sclk_sync[0], sclk_i};
			io_m <= io_i;
			io_s <= io_m;
			cs_d <= cs_sync[1];
			sclk_d <= sclk_sync[1];
		end
	end
	wire cs_n = cs_sync[1];
	wire cs_fall = !cs_n && cs_d;
	wire cs_rise = cs_n && !cs_d;
	wire sclk_rise = sclk_sync[1] && !sclk_d;
	wire sclk_fall = !sclk_sync[1] && sclk_d;
	wire four_line_command_mode = four_line_command_mode_i;
	// --------------------------------------------------------------
	// shared state
	// --------------------------------------------------------------
	srs_state_type state;
	srs_kind_type kind;
	srs_kind_type sv_kind;
	srs_kind_type pend_kind;
	logic [23:0] cnt;
	logic [23:0] sv_cnt;
	logic [23:0] recov;
	logic [8:0] lat;
	logic [10:0] step;
	logic pend;
	logic rst_en;
	logic frame_ok;
	logic [2:0] bit_cnt;
	logic [15:0] byte_cnt;
	logic [7:0] sh_in;
	logic [7:0] opcode;
	logic [23:0] addr;
	logic [23:0] prog_addr;
	logic [3:0] dummy_left;
	logic out_phase;
	logic [2:0] out_cnt;
	logic [7:0] sh_out;
	logic ovf;
	logic [7:0] sec_mem [SECREG_COUNT*SECREG_BYTES];
	logic [7:0] page_buf [PAGE_BYTES];
	logic [PAGE_BYTES-1:0] page_vld;
	logic [7:0] col;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic [7:0] fifo_out_data;
	// --------------------------------------------------------------
	// parameter decode
	// --------------------------------------------------------------
	logic [3:0] dummy_clocks;
	logic [23:0] wrap_mask;
	always_comb begin
		case (read_param_bits_o[DUMMY_LSB +: 2])
			2'h2: dummy_clocks = 4'h6;
			2'h3: dummy_clocks = 4'h8;
			default: dummy_clocks = 4'h4;
		endcase
		wrap_mask = (24'h8 << read_param_bits_o[WRAP_LSB +: 2]) - 24'h1;
	end
	// --------------------------------------------------------------
	// frame capture and read output
	// --------------------------------------------------------------
	wire [7:0] in_byte = four_line_command_mode ? {sh_in[3:0], io_s} : {sh_in[6:0], io_s[0]};
	wire byte_end = four_line_command_mode ? (bit_cnt == 3'h4) : (bit_cnt == 3'h7);
	wire take = sclk_rise && !cs_n && !cs_d && frame_ok && !out_phase;
	wire addr_end = take && byte_end && (byte_cnt == 16'h3);
	wire is_wrap = (opcode == OP_WRAP_READ) && four_line_command_mode;
	wire [1:0] rd_sel = array_addr_o[SEL_LSB +: 2] - 2'h1;
	wire rd_ok = (array_addr_o[15:12] >= 4'h1) && (array_addr_o[15:12] <= 4'h3);
	wire [7:0] sec_byte = rd_ok ? sec_mem[{rd_sel, array_addr_o[9:0]}] : 8'hFF;
	wire [7:0] next_byte = is_wrap ? array_data_i : sec_byte;
	wire [23:0] wrap_next = (array_addr_o & ~wrap_mask) | ((array_addr_o + 24'h1) & wrap_mask);
	wire [23:0] sec_next = {array_addr_o[23:10], array_addr_o[9:0] + 10'h1};
	wire [23:0] next_ptr = is_wrap ? wrap_next : sec_next;
	wire out_start = take && (dummy_left == 4'h1);
	wire out_last = out_cnt == (four_line_command_mode ? 3'h4 : 3'h7);
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			frame_ok <= 1'b0;
			bit_cnt <= 3'h0;
			byte_cnt <= 16'h0;
			sh_in <= 8'h0;
			opcode <= 8'h0;
			addr <= 24'h0;
			dummy_left <= 4'h0;
			out_phase <= 1'b0;
			out_cnt <= 3'h0;
			sh_out <= 8'h0;
			array_addr_o <= 24'h0;
			io_o <= 4'h0;
			io_oe_o <= 4'h0;
		end else begin
			if (cs_fall) begin
				// frames opened during recovery stay dead
				frame_ok <= (recov == 24'h0);
				bit_cnt <= 3'h0;
				byte_cnt <= 16'h0;
				dummy_left <= 4'h0;
				out_phase <= 1'b0;
			end
			if (take) begin
				sh_in <= in_byte;
				bit_cnt <= bit_cnt + (four_line_command_mode ? 3'h4 : 3'h1);
				if (byte_end) begin
					if (byte_cnt != 16'hFFFF) begin
						byte_cnt <= byte_cnt + 16'h1;
					end
					if (byte_cnt == 16'h0) begin
						opcode <= in_byte;
					end else if (byte_cnt <= 16'h3) begin
						addr <= {addr[15:0], in_byte};
					end
				end
				// dummy after the address, then data
				if (addr_end && (opcode == OP_SEC_READ || is_wrap)) begin
					dummy_left <= (opcode == OP_SEC_READ) ?
						(four_line_command_mode ? SEC_DUMMY_QPI : SEC_DUMMY_SPI) : dummy_clocks;
					array_addr_o <= {addr[15:0], in_byte};
				end else if (dummy_left != 4'h0) begin
					dummy_left <= dummy_left - 4'h1;
				end
				if (out_start) begin
					out_phase <= 1'b1;
					out_cnt <= 3'h0;
					sh_out <= next_byte;
					array_addr_o <= next_ptr;
				end
			end
			// data changes on falling clock edges
			if (sclk_fall && out_phase && !cs_n) begin
				io_o <= four_line_command_mode ? sh_out[7:4] : {2'h0, sh_out[7], 1'b0};
				io_oe_o <= four_line_command_mode ? 4'hF : 4'h2;
				out_cnt <= out_cnt + (four_line_command_mode ? 3'h4 : 3'h1);
				if (out_last) begin
					sh_out <= next_byte;
					array_addr_o <= next_ptr;
				end else begin
					sh_out <= four_line_command_mode ? {sh_out[3:0], 4'h0} : {sh_out[6:0], 1'b0};
				end
			end
			if (cs_n) begin
				io_oe_o <= 4'h0;
				out_phase <= 1'b0;
			end
		end
	end
	// --------------------------------------------------------------
	// command decode at chip select rise
	// --------------------------------------------------------------
	wire done = cs_rise && frame_ok;
	wire len8 = (byte_cnt == 16'h1) && (bit_cnt == 3'h0);
	wire len32 = (byte_cnt == 16'h4) && (bit_cnt == 3'h0);
	wire lendata = (byte_cnt >= 16'h5) && (bit_cnt == 3'h0);
	wire [3:0] sel = addr[15:12];
	// upper byte zero, bits 11-10 zero, area 1 to 3
	wire sec_ok = (addr[23:16] == 8'h0) && (addr[11:10] == 2'h0) && (sel >= 4'h1) && (sel <= 4'h3);
	wire [2:0] locks = {otp_lock_bit_three_i, otp_lock_bit_two_i, otp_lock_bit_one_i};
	wire locked = locks[sel[1:0] - 2'h1];
	wire busy = write_in_progress_flag_o || pend || state == ST_SUSP_WAIT || state == ST_RES_WAIT;
	wire psusp = suspend_flags_o[1];
	wire anysusp = suspend_flags_o != 2'h0;
	wire write_latch_flag = write_latch_flag_o;
	wire is_erase = opcode == OP_SE || opcode == OP_BE32 || opcode == OP_BE64;
	wire is_chip = opcode == OP_CE1 || opcode == OP_CE2;
	wire wr_base = done && write_latch_flag && !busy;
	// erase: exact length, latch, unlocked, no suspend
	wire acc_se = wr_base && opcode == OP_SEC_ERASE && len32 && sec_ok && !locked && !anysusp;
	// program needs whole bytes, latch and no program suspend
	wire acc_sp = wr_base && opcode == OP_SEC_PROG && lendata && !ovf && sec_ok && !locked && !psusp;
	wire acc_mp = wr_base && (opcode == OP_PP || opcode == OP_QPP) && lendata && !psusp;
	wire acc_me = wr_base && ((is_erase && len32) || (is_chip && len8)) && !anysusp;
	// only a running page program or sector/block erase
	wire acc_sus = done && opcode == OP_SUSPEND && len8 && state == ST_RUN && !anysusp &&
		write_in_progress_flag_o && (kind == K_MAIN_PROG || kind == K_MAIN_ERASE);
	wire acc_res = done && opcode == OP_RESUME && len8 && anysusp && state == ST_SUSP &&
		!write_in_progress_flag_o;
	// reset only right after enable, either line mode
	wire soft_rst = done && opcode == OP_RST && len8 && rst_en;
	wire clr = rst_i || soft_rst;
	always_ff @(posedge clk_i) begin
		if (clr) begin
			rst_en <= 1'b0;
		end else if (done && byte_cnt != 16'h0) begin
			// any other command cancels the enable
			rst_en <= (opcode == OP_RST_EN) && len8;
		end
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			recov <= 24'h0;
		end else if (soft_rst) begin
			recov <= 24'(RECOV_CYC);
		end else if (recov != 24'h0) begin
			recov <= recov - 24'h1;
		end
	end
	always_ff @(posedge clk_i) begin
		if (clr) begin
			read_param_bits_o <= READ_PARAM_RESET;
		end else if (done && four_line_command_mode && opcode == OP_SET_PARAM && byte_cnt == 16'h2 &&
			bit_cnt == 3'h0) begin
			read_param_bits_o <= addr[7:0];
		end
	end
	// --------------------------------------------------------------
	// program data path
	// --------------------------------------------------------------
	wire push = take && byte_end && opcode == OP_SEC_PROG && byte_cnt >= 16'h4 &&
		!write_in_progress_flag_o;
	wire drain = fifo_out_valid && !write_in_progress_flag_o;
	srs_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk_i(clk_i),
		.rst_i(clr),
		.in_valid_i(push),
		.in_ready_o(fifo_in_ready),
		.in_data_i(in_byte),
		.out_valid_o(fifo_out_valid),
		.out_ready_i(drain),
		.out_data_o(fifo_out_data)
	);
	always_ff @(posedge clk_i) begin
		if (rst_i || cs_fall) begin
			ovf <= 1'b0;
		end else if (push && !fifo_in_ready) begin
			// a lost byte spoils the sequence rather than programming garbage
			ovf <= 1'b1;
		end
	end
	always_ff @(posedge clk_i) begin
		if (drain) begin
			page_buf[col] <= fifo_out_data;
		end
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			page_vld <= '0;
			col <= 8'h0;
		end else if (addr_end && opcode == OP_SEC_PROG && !write_in_progress_flag_o) begin
			page_vld <= '0;
			col <= in_byte;
		end else if (drain) begin
			page_vld[col] <= 1'b1;
			col <= col + 8'h1;
		end
	end
	// --------------------------------------------------------------
	// self-timed operations, suspend and resume
	// --------------------------------------------------------------
	wire start = pend && !fifo_out_valid && (state == ST_IDLE || state == ST_SUSP);
	wire running = state == ST_RUN || state == ST_NEST;
	wire [1:0] wsel = prog_addr[SEL_LSB +: 2] - 2'h1;
	always_ff @(posedge clk_i) begin
		if (clr) begin
			state <= ST_IDLE;
			kind <= K_NONE;
			sv_kind <= K_NONE;
			pend_kind <= K_NONE;
			pend <= 1'b0;
			cnt <= 24'h0;
			sv_cnt <= 24'h0;
			lat <= 9'h0;
			step <= 11'h0;
			prog_addr <= 24'h0;
			// abort, drop busy, latch and suspend
			write_in_progress_flag_o <= 1'b0;
			write_latch_flag_o <= 1'b0;
			suspend_flags_o <= 2'h0;
		end else begin
			if (done && len8 && opcode == OP_LATCH_SET) begin
				write_latch_flag_o <= 1'b1;
			end else if (done && len8 && opcode == OP_LATCH_CLR) begin
				write_latch_flag_o <= 1'b0;
			end
			if (acc_se || acc_sp || acc_mp || acc_me) begin
				pend <= 1'b1;
				prog_addr <= addr;
				write_latch_flag_o <= 1'b0;
				pend_kind <= acc_se ? K_SEC_ERASE : acc_sp ? K_SEC_PROG :
					acc_mp ? K_MAIN_PROG : is_chip ? K_CHIP_ERASE : K_MAIN_ERASE;
			end
			case (state)
				ST_IDLE, ST_SUSP: begin
					if (start) begin
						pend <= 1'b0;
						kind <= pend_kind;
						step <= 11'h0;
						cnt <= (pend_kind == K_SEC_ERASE) ? 24'(SE_CYC) :
							(pend_kind == K_SEC_PROG) ? 24'(SP_CYC) : 24'(MC_CYC);
						// busy for the whole timed cycle
						write_in_progress_flag_o <= 1'b1;
						state <= (state == ST_SUSP) ? ST_NEST : ST_RUN;
					end else if (acc_res) begin
						// flag clears now, busy returns after the delay
						suspend_flags_o <= 2'h0;
						lat <= 9'(RESUME_CYCLES);
						kind <= sv_kind;
						cnt <= sv_cnt;
						state <= ST_RES_WAIT;
					end
				end
				ST_RUN, ST_NEST: begin
					if (step != 11'h7FF) begin
						step <= step + 11'h1;
					end
					if (acc_sus) begin
						suspend_flags_o <= (kind == K_MAIN_PROG) ? 2'h2 : 2'h1;
						lat <= 9'(SUSPEND_CYCLES);
						state <= ST_SUSP_WAIT;
					end else if (cnt <= 24'h1) begin
						write_in_progress_flag_o <= 1'b0;
						state <= (state == ST_NEST) ? ST_SUSP : ST_IDLE;
					end else begin
						cnt <= cnt - 24'h1;
					end
				end
				ST_SUSP_WAIT: begin
					lat <= lat - 9'h1;
					if (lat <= 9'h1) begin
						// busy drops within the suspend latency
						write_in_progress_flag_o <= 1'b0;
						sv_kind <= kind;
						sv_cnt <= cnt;
						state <= ST_SUSP;
					end
				end
				ST_RES_WAIT: begin
					lat <= lat - 9'h1;
					if (lat <= 9'h1) begin
						write_in_progress_flag_o <= 1'b1;
						state <= ST_RUN;
					end
				end
				default: state <= ST_IDLE;
			endcase
		end
	end
	// one byte per cycle of the timed walk
	always_ff @(posedge clk_i) begin
		if (running && kind == K_SEC_ERASE && step < 11'(SECREG_BYTES)) begin
			sec_mem[{wsel, step[9:0]}] <= 8'hFF;
		end else if (running && kind == K_SEC_PROG && step < 11'(PAGE_BYTES) &&
			page_vld[step[7:0]]) begin
			sec_mem[{wsel, prog_addr[9:8], step[7:0]}] <=
				sec_mem[{wsel, prog_addr[9:8], step[7:0]}] & page_buf[step[7:0]];
		end
	end
	// --------------------------------------------------------------
	// assertions
	// --------------------------------------------------------------
	sequence s_sus_req;
		acc_sus;
	endsequence
	sequence s_sus_done;
		suspend_flags_o != 2'h0 ##[1:SUS_MAX] !write_in_progress_flag_o;
	endsequence
	a_erase_latch: assert property (@(posedge clk_i) disable iff (rst_i)
		done && opcode == OP_SEC_ERASE && !write_latch_flag |=> !pend)
		else $error("erase taken without write latch");
	a_erase_length: assert property (@(posedge clk_i) disable iff (rst_i)
		acc_se |-> byte_cnt == 16'h4 && bit_cnt == 3'h0)
		else $error("erase taken with wrong length");
	a_lock_block: assert property (@(posedge clk_i) disable iff (rst_i)
		(acc_se || acc_sp) |-> !((sel == 4'h1 && otp_lock_bit_one_i) ||
		(sel == 4'h2 && otp_lock_bit_two_i) || (sel == 4'h3 && otp_lock_bit_three_i)))
		else $error("locked area accepted a write");
	a_busy_latch: assert property (@(posedge clk_i) disable iff (rst_i)
		start |=> write_in_progress_flag_o && !write_latch_flag_o)
		else $error("busy or latch wrong at op start");
	a_read_wrap: assert property (@(posedge clk_i) disable iff (rst_i)
		out_start && !is_wrap && array_addr_o[9:0] == 10'h3FF |=> array_addr_o[9:0] == 10'h0)
		else $error("read offset did not wrap");
	a_reset_enable: assert property (@(posedge clk_i) disable iff (rst_i)
		soft_rst |-> rst_en ##1 !write_latch_flag_o && suspend_flags_o == 2'h0)
		else $error("reset without enable or state kept");
	a_recov_refuse: assert property (@(posedge clk_i) disable iff (rst_i)
		cs_fall && recov != 24'h0 |=> !frame_ok)
		else $error("frame accepted during recovery");
	a_suspend_seq: assert property (@(posedge clk_i) disable iff (rst_i || soft_rst)
		s_sus_req |=> s_sus_done)
		else $error("suspend flag or busy drop late");
	a_suspend_gate: assert property (@(posedge clk_i) disable iff (rst_i)
		acc_sus |-> write_in_progress_flag_o && suspend_flags_o == 2'h0)
		else $error("suspend accepted while idle or suspended");
	a_psusp_block: assert property (@(posedge clk_i) disable iff (rst_i)
		psusp |-> !(acc_se || acc_sp || acc_mp || acc_me))
		else $error("write accepted in program suspend");
	a_resume_seq: assert property (@(posedge clk_i) disable iff (rst_i || soft_rst)
		acc_res |=> suspend_flags_o == 2'h0 ##[1:RES_MAX] write_in_progress_flag_o)
		else $error("resume timing wrong");
	a_dummy_map: assert property (@(posedge clk_i) disable iff (rst_i)
		read_param_bits_o[5:4] == 2'h2 |-> dummy_clocks == 4'h6)
		else $error("dummy count mapping wrong");
endmodule

// file: tb/srs_host.sv
// Purpose: host-side serial controller model for the command logic
// Assumes: single-line or four-line mode, 64 ns link clock
// Notes: link clock stands still low outside frames
`timescale 1ns/1ps
module srs_host (
	output logic cs_n_o,
	output logic sclk_o,
	output logic [3:0] io_o,
	input wire logic [3:0] io_i,
	output logic done_o,
	output logic [7:0] rd_o
);
	initial begin
		cs_n_o = 1'b1;
		sclk_o = 1'b0;
		io_o = 4'hA;
		done_o = 1'b0;
		rd_o = 8'h00;
	end
	// msb first on rises, cs high right after last bit
	// n counts bits in single-line mode and nibbles in four-line mode
	task automatic frame(input logic [63:0] bits, input int n, input int nrd, input logic quad);
		rd_o = 8'h00;
		cs_n_o = 1'b0;
		for (int i = n - 1; i >= 0; i--) begin
			if (quad) begin
				io_o = bits[4*i +: 4];
			end else begin
				io_o[0] = bits[i];
			end
			#32 sclk_o = 1'b1;
			#32 sclk_o = 1'b0;
		end
		// released lines show the inverse, not a stale level
		io_o = ~io_o;
		for (int i = 0; i < (quad ? 2 : 8) * nrd; i++) begin
			#32 sclk_o = 1'b1;
			rd_o = quad ? {rd_o[3:0], io_i} : {rd_o[6:0], io_i[1]};
			#32 sclk_o = 1'b0;
		end
		cs_n_o = 1'b1;
		#64 done_o = 1'b1;
		#4 done_o = 1'b0;
	endtask
endmodule

// file: tb/srs_cmd_tb_top.sv
// Purpose: self-checking bench for the security register / reset / suspend logic
// Assumes: short timing parameters, both line modes
// Notes: status word is {busy, latch, suspend[1:0], read byte}
`timescale 1ns/1ps
module srs_cmd_tb_top import srs_pkg::*; ;
	logic clk_i = 1'b0, rst_i = 1'b1, cs_n, sclk, done, write_in_progress_flag, write_latch_flag;
	logic l1 = 1'b0, l2 = 1'b0, l3 = 1'b0, quad = 1'b0;
	logic [3:0] hio, io_out, io_oe, io_in;
	logic [7:0] adata = 8'h00, rd, par, pdat;
	logic [23:0] aaddr;
	logic [1:0] sus;
	logic [11:0] q[$];
	int failures = 0, cmp_count = 0;
	always #2 clk_i = ~clk_i;
	// array model: byte is its low address bits scrambled by the random salt
	always @(posedge clk_i) adata <= aaddr[7:0] ^ pdat;
	// wire level: device drives where enabled, host elsewhere
	assign io_in = (io_oe & io_out) | (~io_oe & hio);
	srs_host host_u (.cs_n_o(cs_n), .sclk_o(sclk), .io_o(hio), .io_i(io_in), .done_o(done),
		.rd_o(rd));
	srs_cmd #(.SECREG_ERASE_TIME_US(1), .SECREG_PROG_TIME_US(1), .MAIN_OP_TIME_US(2),
		.RESET_RECOVERY_US(1)) dut_u (.clk_i(clk_i), .rst_i(rst_i),
		.cs_n_i(cs_n), .sclk_i(sclk), .io_i(io_in), .io_o(io_out), .io_oe_o(io_oe),
		.four_line_command_mode_i(quad), .otp_lock_bit_one_i(l1), .otp_lock_bit_two_i(l2),
		.otp_lock_bit_three_i(l3), .array_data_i(adata), .array_addr_o(aaddr),
		.write_in_progress_flag_o(write_in_progress_flag), .write_latch_flag_o(write_latch_flag), .suspend_flags_o(sus),
		.read_param_bits_o(par));
	task automatic chk(input string name, input logic [11:0] seen, input logic [11:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			$display("BAD %s exp %h seen %h", name, exp, seen);
			failures++;
		end
	endtask
	task automatic finish_test();
		if (failures == 0 && cmp_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic op(input logic [63:0] bits, input int n, input int nrd, input logic [11:0] e);
		q.push_back(e);
		@(posedge clk_i);
		#1 host_u.frame(bits, n, nrd, quad);
	endtask
	task automatic wait_idle();
		int k;
		for (k = 0; k < 3000 && write_in_progress_flag !== 1'b0; k++) @(posedge clk_i);
		if (k == 3000) failures++;
	endtask
	// each finished frame yields one result, checked against the oldest note
	always @(posedge done) chk("status", {write_in_progress_flag, write_latch_flag, sus, rd}, q.pop_front());
	initial begin
		#200000 failures++;
		finish_test();
	end
	initial begin
		pdat = 8'($urandom(27391));
		repeat (8) @(posedge clk_i);
		#1 rst_i = 1'b0;
		repeat (4) @(posedge clk_i);
		chk("params", {4'h0, par}, 12'h000);
		op({OP_SEC_ERASE, 24'h001000}, 32, 0, 12'h000);
		op(OP_LATCH_SET, 8, 0, 12'h400);
		op({OP_SEC_ERASE, 24'h001000, 1'b0}, 33, 0, 12'h400);
		l1 = 1'b1;
		op({OP_SEC_ERASE, 24'h001000}, 32, 0, 12'h400);
		l1 = 1'b0;
		l2 = 1'b1;
		op({OP_SEC_ERASE, 24'h001000}, 32, 0, 12'h800);
		l2 = 1'b0;
		wait_idle();
		op({OP_SEC_READ, 24'h0013FF, 8'h00}, 40, 2, 12'h0FF);
		op(OP_LATCH_SET, 8, 0, 12'h400);
		op({OP_SEC_PROG, 24'h001105, pdat}, 40, 0, 12'h800);
		wait_idle();
		op({OP_SEC_READ, 24'h001105, 8'h00}, 40, 1, {4'h0, pdat});
		op(OP_LATCH_SET, 8, 0, 12'h400);
		op({OP_SEC_PROG, 24'h001105, pdat[7:4]}, 36, 0, 12'h400);
		op(OP_RST_EN, 8, 0, 12'h400);
		op(OP_RST, 8, 0, 12'h000);
		op(OP_LATCH_SET, 8, 0, 12'h000);
		#1100;
		op(OP_LATCH_SET, 8, 0, 12'h400);
		op(OP_RST_EN, 8, 0, 12'h400);
		op(OP_LATCH_SET, 8, 0, 12'h400);
		op(OP_RST, 8, 0, 12'h400);
		op({OP_SE, 24'h000000}, 32, 0, 12'h800);
		op(OP_SUSPEND, 8, 0, 12'h900);
		wait_idle();
		op(OP_LATCH_SET, 8, 0, 12'h500);
		op({OP_SEC_ERASE, 24'h002000}, 32, 0, 12'h500);
		op(OP_RESUME, 8, 0, 12'h400);
		op(OP_LATCH_SET, 8, 0, 12'hC00);
		wait_idle();
		quad = 1'b1;
		op({OP_SET_PARAM, 8'h21}, 4, 0, 12'h400);
		chk("params", {4'h0, par}, 12'h021);
		op({OP_WRAP_READ, 24'h00000F, 24'h000000}, 14, 2, {4'h4, pdat});
		op({OP_SEC_READ, 24'h001105, 8'h00}, 10, 1, {4'h4, pdat});
		op(OP_RST_EN, 2, 0, 12'h400);
		op(OP_RST, 2, 0, 12'h000);
		chk("params", {4'h0, par}, 12'h000);
		finish_test();
	end
endmodule
